// file: hw/i2c_slave_register_port.v
// Purpose: two-wire slave port giving a master access to 8-bit registers
// Assumes: scl and sda inputs are asynchronous; scl slow vs clk
// Notes: register storage lives outside; reads return rd_data
`timescale 1ns/100ps
`include "i2c_slave_defs.vh"

// Notes on behaviour
// - sda sampled at scl rise; device changes sda only while scl low
// - sda falling while scl high is start
// - sda rising while scl high is stop; transaction ends
// - sender releases after 8 bits; receiver pulls low on 9th
// - first byte msb first; upper seven bits compared to 1000011
// - address lsb one means read, zero means write
// - matching address acknowledged in ninth bit period
// - first write byte is sub-address, loaded into counter, acknowledged
// - single write: one data byte acknowledged and stored, then stop
// - multibyte write stores successive bytes until stop
// - counter increments after every byte written or read
// - current-address read returns register at counter
// - master ack requests next byte; nack ends burst
// - sequential read from either start kind; counter advances
// - slave only; never drives scl or starts transfer
// - registers eight bits; exactly eight bits per access
// - registers without reset value have undefined content
module i2c_slave_register_port #(
   parameter AW = 8 // sub-address width
) (
   input wire clk,             // system clock, 25 MHz
   input wire arst_n,          // asynchronous reset, active low
   input wire ce,              // clock enable, freezes state when low
   input wire scl_i,           // bus clock pin level
   input wire sda_i,           // bus data pin level
   output wire sda_o,          // bus data drive value, always low
   output reg sda_oe,          // high while pulling sda low
   output reg [AW-1:0] reg_addr_q, // current register address
   output reg [7:0] wr_data_q, // byte to store
   output reg wr_stb_q,        // one-cycle write strobe
   input wire [7:0] rd_data,   // register content at reg_addr_q
   output reg rd_stb_q,        // one-cycle pulse when a byte is fetched
   output reg busy_q           // addressed transaction in progress
);
   localparam S_IDLE = 3'h0;
   localparam S_ADDR = 3'h1;
   localparam S_SUB = 3'h2;
   localparam S_WDAT = 3'h3;
   localparam S_RDAT = 3'h4;
   localparam S_RACK = 3'h5;

   reg rst_m_q;
   reg rst_n_q;
   wire scl_q;
   wire sda_q;
   wire scl_rise;
   wire scl_fall;
   wire sda_rise;
   wire sda_fall;
   reg [2:0] state_q;
   reg [3:0] bit_cnt_q;
   reg [7:0] shift_q;
   reg ack_phase_q;
   reg [7:0] tx_q;
   reg ack_ok_q;

   // open-drain drive for bit idx of a byte, msb first; a zero pulls low
   function oe_for_bit;
      input [7:0] data;
      input [2:0] idx;
      begin
         oe_for_bit = ~data[3'h7 - idx];
      end
   endfunction

   // reset release through two flops
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   i2c_line_sync u_scl (
      .clk(clk),
      .rst_n(rst_n_q),
      .ce(ce),
      .line_in(scl_i),
      .level_q(scl_q),
      .rise(scl_rise),
      .fall(scl_fall)
   );

   i2c_line_sync u_sda (
      .clk(clk),
      .rst_n(rst_n_q),
      .ce(ce),
      .line_in(sda_i),
      .level_q(sda_q),
      .rise(sda_rise),
      .fall(sda_fall)
   );

   // open drain: only ever pulls low; scl is never driven
   assign sda_o = 1'b0;

   // start/stop detection, byte shifting and the protocol machine
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= S_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         ack_phase_q <= 1'b0;
         tx_q <= 8'h00;
         ack_ok_q <= 1'b0;
         sda_oe <= 1'b0;
         reg_addr_q <= {AW{1'b0}};
         wr_data_q <= 8'h00;
         wr_stb_q <= 1'b0;
         rd_stb_q <= 1'b0;
         busy_q <= 1'b0;
      end else if (ce) begin
         wr_stb_q <= 1'b0;
         rd_stb_q <= 1'b0;
         if (sda_fall && scl_q) begin
            // start or repeated start: counter is kept across it
            state_q <= S_ADDR;
            bit_cnt_q <= 4'h0;
            ack_phase_q <= 1'b0;
            sda_oe <= 1'b0;
            busy_q <= 1'b0;
         end else if (sda_rise && scl_q) begin
            state_q <= S_IDLE;
            sda_oe <= 1'b0;
            busy_q <= 1'b0;
         end else if (scl_rise) begin
            // sample on rising scl
            if (!ack_phase_q && state_q != S_IDLE) begin
               shift_q <= {shift_q[6:0], sda_q};
               bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (ack_phase_q && state_q == S_RACK) begin
               ack_ok_q <= ~sda_q;
            end
         end else if (scl_fall) begin
            // all sda changes happen just after scl falls
            if (ack_phase_q) begin
               ack_phase_q <= 1'b0;
               bit_cnt_q <= 4'h0;
               sda_oe <= 1'b0;
               if (state_q == S_RACK) begin
                  if (ack_ok_q) begin
                     // next byte in sequence
                     state_q <= S_RDAT;
                     tx_q <= rd_data; // taken as given
                     rd_stb_q <= 1'b1;
                     sda_oe <= oe_for_bit(rd_data, 3'h0);
                  end else begin
                     state_q <= S_IDLE;
                  end
               end else if (state_q == S_RDAT) begin
                  tx_q <= rd_data;
                  rd_stb_q <= 1'b1;
                  sda_oe <= oe_for_bit(rd_data, 3'h0);
               end
            end else if (state_q == S_RDAT) begin
               if (bit_cnt_q == `BITS_PER_BYTE) begin
                  // release for master ack, then advance counter
                  sda_oe <= 1'b0;
                  ack_phase_q <= 1'b1;
                  ack_ok_q <= 1'b0;
                  state_q <= S_RACK;
                  reg_addr_q <= reg_addr_q + 1'b1;
               end else begin
                  sda_oe <= oe_for_bit(tx_q, bit_cnt_q[2:0]);
               end
            end else if (bit_cnt_q == `BITS_PER_BYTE) begin
               ack_phase_q <= 1'b1;
               case (state_q)
                  S_ADDR: begin
                     if (shift_q[7:1] == `DEV_ADDR) begin
                        sda_oe <= 1'b1;
                        busy_q <= 1'b1;
                        if (shift_q[0] == `RW_READ) begin
                           state_q <= S_RDAT;
                        end else begin
                           state_q <= S_SUB;
                        end
                     end else begin
                        state_q <= S_IDLE;
                        ack_phase_q <= 1'b0;
                     end
                  end
                  S_SUB: begin
                     reg_addr_q <= shift_q[AW-1:0];
                     sda_oe <= 1'b1;
                     state_q <= S_WDAT;
                  end
                  S_WDAT: begin
                     // store and advance; repeats until stop
                     wr_data_q <= shift_q;
                     wr_stb_q <= 1'b1;
                     sda_oe <= 1'b1;
                  end
                  default: begin
                     ack_phase_q <= 1'b0;
                  end
               endcase
            end
         end
         // counter steps after the write strobe so the store sees old addr
         if (wr_stb_q) begin
            reg_addr_q <= reg_addr_q + 1'b1;
         end
      end
   end
endmodule

// file: common/i2c_slave_defs.vh
// Purpose: constants for the two-wire slave register port
// Assumes: included by bare name from hw/ files
// Notes: definitions only
`ifndef I2C_SLAVE_DEFS_VH
`define I2C_SLAVE_DEFS_VH
`define DEV_ADDR 7'h43
`define RW_READ 1'b1
`define BITS_PER_BYTE 4'h8
`define ADDR_CNT_RST 8'h00
`endif

// file: hw/i2c_line_sync.v
// Purpose: two-flop synchroniser plus edge detection for one bus line
// Assumes: line is asynchronous to clk
// Notes: first flop is read only by the second
`timescale 1ns/100ps
module i2c_line_sync (
   input wire clk,        // system clock
   input wire rst_n,      // synchronised reset, active low
   input wire ce,         // clock enable
   input wire line_in,    // raw pin level
   output reg level_q,    // synchronised level
   output wire rise,      // one-cycle rising pulse
   output wire fall       // one-cycle falling pulse
);
   reg meta_q;
   reg sync_q;

   // lines idle high, so reset to one to avoid a false edge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         level_q <= 1'b1;
      end else if (ce) begin
         meta_q <= line_in;
         sync_q <= meta_q;
         level_q <= sync_q;
      end
   end

   // edges compare the second and third stages only
   assign rise = ce & sync_q & ~level_q;
   assign fall = ce & ~sync_q & level_q;
endmodule

// file: tb/i2c_port_sva.sv
// Purpose: assertions on the two-wire slave port
// Assumes: ce held high by the bench
// Notes: bound to every instance of the port
`timescale 1ns/100ps
module i2c_port_sva #(parameter AW = 8) (
   input wire clk, // clock
   input wire arst_n, // reset, active low
   input wire ce, // enable
   input wire scl_i, // bus clock
   input wire sda_i, // bus data
   input wire sda_o, // drive value
   input wire sda_oe, // drive enable
   input wire [AW-1:0] reg_addr_q, // address counter
   input wire [7:0] wr_data_q, // write data
   input wire wr_stb_q, // write strobe
   input wire [7:0] rd_data, // read data
   input wire rd_stb_q, // read strobe
   input wire busy_q // transaction flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_drv; sda_o == 1'b0; endproperty
   a_drv: assert property (p_drv) else $error("sda drive high");
   property p_wpulse; wr_stb_q |=> !wr_stb_q; endproperty
   a_wpulse: assert property (p_wpulse) else $error("long wr");
   property p_winc; wr_stb_q |=> reg_addr_q == $past(reg_addr_q) + 1'b1;
   endproperty
   a_winc: assert property (p_winc) else $error("no inc");
   property p_wbusy; wr_stb_q |-> busy_q; endproperty
   a_wbusy: assert property (p_wbusy) else $error("idle wr");
   property p_rbusy; rd_stb_q |-> busy_q; endproperty
   a_rbusy: assert property (p_rbusy) else $error("idle rd");
   property p_rgap; rd_stb_q |=> !rd_stb_q [*8]; endproperty
   a_rgap: assert property (p_rgap) else $error("rd gap");
   property p_idle; !busy_q |=> $stable(reg_addr_q); endproperty
   a_idle: assert property (p_idle) else $error("idle addr");
   property p_wst; wr_stb_q |-> $stable(reg_addr_q); endproperty
   a_wst: assert property (p_wst) else $error("wr addr");
   property p_oels; $changed(sda_oe) |-> !scl_i; endproperty
   a_oels: assert property (p_oels) else $error("oe scl hi");
   property p_oeb; sda_oe |-> busy_q; endproperty
   a_oeb: assert property (p_oeb) else $error("oe idle");
endmodule
bind i2c_slave_register_port i2c_port_sva #(.AW(AW)) i_i2c_port_sva (
   .clk(clk), .arst_n(arst_n), .ce(ce), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .reg_addr_q(reg_addr_q),
   .wr_data_q(wr_data_q), .wr_stb_q(wr_stb_q), .rd_data(rd_data),
   .rd_stb_q(rd_stb_q), .busy_q(busy_q));

// file: tb/i2c_master_model.sv
// Purpose: bus master model for the slave port
// Assumes: 25 MHz clk, 320 ns bus bit
// Notes: open drain; a released line is pulled high
`timescale 1ns/100ps
module i2c_master_model (
   input wire clk, // system clock
   input wire sda_w, // wired data level
   output reg scl, // bus clock, idles high
   output reg sda_m // data drive, 1 releases
);
   // wait a quarter bit
   task q;
      repeat (2) @(posedge clk);
   endtask
   // data moves only with the clock low; sampled in the high phase
   task bit_io(input b, output s);
      begin
         scl <= 1'b0;
         q;
         sda_m <= b;
         q;
         scl <= 1'b1;
         q;
         s = sda_w;
         q;
      end
   endtask
   task start;
      reg s;
      begin
         bit_io(1'b1, s);
         sda_m <= 1'b0;
         q;
         q;
      end
   endtask
   task stop;
      reg s;
      begin
         bit_io(1'b0, s);
         sda_m <= 1'b1;
         q;
         q;
      end
   endtask
   // eight bits msb first, then release for the ack
   task wbyte(input [7:0] b, output ack);
      integer i;
      reg s;
      begin
         for (i = 7; i >= 0; i = i - 1) bit_io(b[i], s);
         bit_io(1'b1, s);
         ack = ~s;
      end
   endtask
   task rbyte(input ack, output [7:0] d);
      integer i;
      reg s;
      begin
         for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, d[i]);
         bit_io(~ack, s);
      end
   endtask
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
endmodule

// file: tb/i2c_slave_register_port_test.sv
// Purpose: self-checking bench for the slave port
// Assumes: register file modelled here, contents preset
// Notes: ce is tied high
`timescale 1ns/100ps
`include "i2c_slave_defs.vh"
module i2c_slave_register_port_test;
   reg clk = 1'b0;
   reg arst_n = 1'b0;
   wire scl, sda_m, sda_o, sda_oe, wr_stb_q, rd_stb_q, busy_q;
   wire [7:0] reg_addr_q, wr_data_q;
   wire sda_w = sda_m & (sda_o | ~sda_oe); // pulled up when released
   reg [7:0] mem [0:255]; // all plain read/write
   integer fail_count = 0;
   integer num_checks = 0;
   integer i;
   reg a;
   reg [7:0] d, e;
   always #20 clk = ~clk;
   // register storage behind the port
   always @(posedge clk) if (wr_stb_q) mem[reg_addr_q] <= wr_data_q;
   i2c_slave_register_port i_i2c_slave_register_port (.clk(clk),
      .arst_n(arst_n), .ce(1'b1), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe(sda_oe), .reg_addr_q(reg_addr_q), .wr_data_q(wr_data_q),
      .wr_stb_q(wr_stb_q), .rd_data(mem[reg_addr_q]), .rd_stb_q(rd_stb_q),
      .busy_q(busy_q));
   i2c_master_model i_i2c_master_model (.clk(clk), .sda_w(sda_w),
      .scl(scl), .sda_m(sda_m));
   task chk(input [7:0] got, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task final_report;
      begin
         if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   task s_nomatch;
      begin
         i_i2c_master_model.start;
         i_i2c_master_model.wbyte(8'h88, a);
         chk({7'h00, a}, 8'h00);
         i_i2c_master_model.wbyte({`DEV_ADDR, 1'b0}, a);
         chk({7'h00, a}, 8'h00);
         i_i2c_master_model.stop;
      end
   endtask
   task s_write;
      begin
         i_i2c_master_model.start;
         i_i2c_master_model.wbyte({`DEV_ADDR, 1'b0}, a);
         chk({7'h00, a}, 8'h01);
         i_i2c_master_model.wbyte(8'hFE, a);
         chk({7'h00, a}, 8'h01);
         for (i = 1; i <= 3; i = i + 1) begin
            e = 8'h11 * i[7:0];
            i_i2c_master_model.wbyte(e, a);
            chk({7'h00, a}, 8'h01);
         end
         i_i2c_master_model.stop;
         chk(mem[8'hFE], 8'h11);
         chk(mem[8'hFF], 8'h22);
         chk(mem[8'h00], 8'h33);
         chk(reg_addr_q, 8'h01);
      end
   endtask
   // sub-address write, repeated start, burst of three
   task s_rread;
      begin
         i_i2c_master_model.start;
         i_i2c_master_model.wbyte({`DEV_ADDR, 1'b0}, a);
         i_i2c_master_model.wbyte(8'hFE, a);
         i_i2c_master_model.start;
         i_i2c_master_model.wbyte({`DEV_ADDR, `RW_READ}, a);
         chk({7'h00, a}, 8'h01);
         for (i = 1; i <= 3; i = i + 1) begin
            e = 8'h11 * i[7:0];
            i_i2c_master_model.rbyte(i < 3, d);
            chk(d, e);
         end
         i_i2c_master_model.stop;
      end
   endtask
   task s_cread;
      begin
         i_i2c_master_model.start;
         i_i2c_master_model.wbyte({`DEV_ADDR, `RW_READ}, a);
         chk({7'h00, a}, 8'h01);
         i_i2c_master_model.rbyte(1'b0, d);
         chk(d, 8'h01 ^ 8'h5A);
         i_i2c_master_model.stop;
         chk(reg_addr_q, 8'h02);
      end
   endtask
   // cut a hang short
   initial begin
      repeat (20000) @(posedge clk);
      fail_count = fail_count + 1;
      final_report;
   end
   initial begin
      for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'h5A;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (10) @(posedge clk);
      s_nomatch;
      s_write;
      s_rread;
      s_cread;
      final_report;
   end
endmodule
